// ### rtl/keyboard_glue_config.sv
// keyboard microcontroller glue: isolation, irq latching, fast port, wake clock
//
// Summary of operation
// - bit 7 picks microcontroller port line polarity: 0 active low, 1 active high
// - bit 6 set blocks mouse clock and data toward the microcontroller
// - mouse data toward mouse wake logic is never blocked
// - bit 5 set blocks keyboard clock and data toward the microcontroller
// - keyboard data toward keyboard wake logic is never blocked
// - bit 4 clear: mouse irq is raw AND latched; set: latched alone
// - bit 3 clear: keyboard irq is raw AND latched; set: latched alone
// - bit 2 enables the fast reset and address gate port
// - keyboard device indices 0xf1 to 0xff are reserved and read zero
// - slow clock bit 0: 0 clock connected, 1 pin grounded, no clock
// - slow clock bit 1: 0 specific key wake logic on, 1 off
// - with wake logic off, the slow clock to it is gated off
`timescale 1ns/100ps
`include "keyboard_glue_config_params.svh"

module keyboard_glue_config
(
    // clock, reset, enable
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire logic                  clken,
    // axi4-lite write address
    input  wire logic [`KGC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read address
    input  wire logic [`KGC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // axi4-lite read data
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // keyboard and mouse lines from the connectors
    input  wire logic                  kbd_clk_line,
    input  wire logic                  keyboard_data_line,
    input  wire logic                  mouse_clk_line,
    input  wire logic                  mouse_data_line,
    // lines toward the microcontroller
    output logic                       mcu_kbd_clk,
    output logic                       mcu_kbd_data,
    output logic                       mcu_mouse_clk,
    output logic                       mcu_mouse_data,
    // lines toward the wake logic
    output logic                       kbd_wake_data,
    output logic                       mouse_wake_data,
    // microcontroller interrupts and port line
    input  wire logic                  mcu_keyboard_interrupt,
    input  wire logic                  mcu_mouse_interrupt,
    input  wire logic                  irq_ack,
    input  wire logic                  mcu_port_assert,
    output logic                       keyboard_interrupt,
    output logic                       mouse_interrupt,
    output logic                       microcontroller_port_line,
    // fast reset and address gate port
    input  wire logic                  fast_port_wr,
    input  wire logic [1:0]            fast_port_data,
    output logic                       address_line_twenty_gate,
    output logic                       keyboard_reset_out,
    // slow clock toward specific key wake logic
    input  wire logic                  slow_clock_pin,
    output logic                       wake_slow_clock
);

    keyboard_glue_config_pkg::state_s state_q;
    keyboard_glue_config_pkg::state_s state_d;

    logic                              wake_off;
    logic                              clk_absent;
    keyboard_glue_config_pkg::reg_idx_t ar_idx;

    assign wake_off   = state_q.pme_cfg[`KGC_WAKE_OFF_BIT];
    assign clk_absent = state_q.pme_cfg[`KGC_CLK_ABSENT_BIT];
    assign ar_idx     = s_axi_araddr[`KGC_ADDR_W-1:2];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        if (clken)
        begin
            // write channel: address and data taken in either order
            if (s_axi_awvalid && state_q.awready)
            begin
                state_d.aw_got = 1'b1;
                state_d.aw_idx = s_axi_awaddr[`KGC_ADDR_W-1:2];
            end
            if (s_axi_wvalid && state_q.wready)
            begin
                state_d.w_got   = 1'b1;
                state_d.w_data  = s_axi_wdata[7:0];
                state_d.w_strb0 = s_axi_wstrb[0];
            end
            if (state_q.bvalid && s_axi_bready)
            begin
                state_d.bvalid = 1'b0;
            end
            if (state_q.aw_got && state_q.w_got && !state_q.bvalid)
            begin
                state_d.aw_got = 1'b0;
                state_d.w_got  = 1'b0;
                state_d.bvalid = 1'b1;
                state_d.bresp  = `KGC_RESP_OKAY;
                if (state_q.aw_idx == `KGC_KBD_CFG_IDX)
                begin
                    if (state_q.w_strb0)
                    begin
                        state_d.kbd_cfg = state_q.w_data & `KGC_KBD_CFG_MASK;
                    end
                end
                else if (state_q.aw_idx == `KGC_PME_CFG_IDX)
                begin
                    if (state_q.w_strb0)
                    begin
                        state_d.pme_cfg = state_q.w_data & `KGC_PME_CFG_MASK;
                    end
                end
                // reserved range and status accept writes and ignore them
                else if (!((state_q.aw_idx >= `KGC_RSVD_LO_IDX
                            && state_q.aw_idx <= `KGC_RSVD_HI_IDX)
                           || state_q.aw_idx == `KGC_STATUS_IDX))
                begin
                    state_d.bresp = `KGC_RESP_DECERR;
                end
            end
            // one write in flight; readies reopen after the response
            state_d.awready = !state_d.aw_got && !state_d.bvalid;
            state_d.wready  = !state_d.w_got && !state_d.bvalid;

            // read channel
            if (state_q.rvalid && s_axi_rready)
            begin
                state_d.rvalid = 1'b0;
            end
            if (s_axi_arvalid && state_q.arready)
            begin
                state_d.rvalid = 1'b1;
                state_d.rresp  = `KGC_RESP_OKAY;
                state_d.rdata  = 32'h0000_0000;
                if (ar_idx == `KGC_KBD_CFG_IDX)
                begin
                    state_d.rdata = {24'h00_0000, state_q.kbd_cfg};
                end
                else if (ar_idx == `KGC_PME_CFG_IDX)
                begin
                    state_d.rdata = {24'h00_0000, state_q.pme_cfg};
                end
                else if (ar_idx == `KGC_STATUS_IDX)
                begin
                    state_d.rdata = {28'h000_0000, state_q.wake_clk, state_q.a20_gate,
                                     state_q.mouse_latch, state_q.kbd_latch};
                end
                else if (!(ar_idx >= `KGC_RSVD_LO_IDX && ar_idx <= `KGC_RSVD_HI_IDX))
                begin
                    state_d.rresp = `KGC_RESP_DECERR; // reserved stays okay and zero
                end
            end
            state_d.arready = !state_d.rvalid;

            // isolation forces idle high toward the microcontroller
            state_d.mcu_mouse_clk  = state_q.kbd_cfg[`KGC_MOUSE_ISO_BIT]
                                     | mouse_clk_line;
            state_d.mcu_mouse_data = state_q.kbd_cfg[`KGC_MOUSE_ISO_BIT]
                                     | mouse_data_line;
            state_d.mcu_kbd_clk    = state_q.kbd_cfg[`KGC_KBD_ISO_BIT]
                                     | kbd_clk_line;
            state_d.mcu_kbd_data   = state_q.kbd_cfg[`KGC_KBD_ISO_BIT]
                                     | keyboard_data_line;
            state_d.mouse_wake_data = mouse_data_line;
            state_d.kbd_wake_data   = keyboard_data_line;

            // latches set on a rising irq; set wins over the ack
            state_d.kbd_irq_prev   = mcu_keyboard_interrupt;
            state_d.mouse_irq_prev = mcu_mouse_interrupt;
            if (irq_ack)
            begin
                state_d.kbd_latch   = 1'b0;
                state_d.mouse_latch = 1'b0;
            end
            if (mcu_keyboard_interrupt && !state_q.kbd_irq_prev)
            begin
                state_d.kbd_latch = 1'b1;
            end
            if (mcu_mouse_interrupt && !state_q.mouse_irq_prev)
            begin
                state_d.mouse_latch = 1'b1;
            end
            state_d.mouse_irq_out = state_q.kbd_cfg[`KGC_MOUSE_IRQ_LATCH_MODE_BIT] ? state_q.mouse_latch
                                  : (mcu_mouse_interrupt & state_q.mouse_latch);
            state_d.kbd_irq_out   = state_q.kbd_cfg[`KGC_KEY_IRQ_LATCH_MODE_BIT] ? state_q.kbd_latch
                                  : (mcu_keyboard_interrupt & state_q.kbd_latch);

            // polarity of the port line
            state_d.port_line_out = state_q.kbd_cfg[`KGC_PORT_POL_BIT] ? mcu_port_assert
                                  : !mcu_port_assert;

            // fast port: reset is a one-cycle pulse, gate holds
            state_d.keyboard_reset_out_out = 1'b0;
            if (fast_port_wr && state_q.kbd_cfg[`KGC_FAST_EN_BIT])
            begin
                state_d.a20_gate   = fast_port_data[1];
                state_d.keyboard_reset_out_out = fast_port_data[0];
            end

            // gating the clock here keeps the wake logic from toggling at all
            state_d.wake_clk = slow_clock_pin & !wake_off & !clk_absent;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q                <= '0;
            state_q.kbd_cfg        <= `KGC_KBD_CFG_RST;
            state_q.pme_cfg        <= `KGC_PME_CFG_RST;
            state_q.mcu_kbd_clk    <= 1'b1;
            state_q.mcu_kbd_data   <= 1'b1;
            state_q.mcu_mouse_clk  <= 1'b1;
            state_q.mcu_mouse_data <= 1'b1;
            state_q.kbd_wake_data  <= 1'b1;
            state_q.mouse_wake_data <= 1'b1;
            state_q.port_line_out  <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign s_axi_awready             = state_q.awready;
    assign s_axi_wready              = state_q.wready;
    assign s_axi_bresp               = state_q.bresp;
    assign s_axi_bvalid              = state_q.bvalid;
    assign s_axi_arready             = state_q.arready;
    assign s_axi_rdata               = state_q.rdata;
    assign s_axi_rresp               = state_q.rresp;
    assign s_axi_rvalid              = state_q.rvalid;
    assign mcu_kbd_clk               = state_q.mcu_kbd_clk;
    assign mcu_kbd_data              = state_q.mcu_kbd_data;
    assign mcu_mouse_clk             = state_q.mcu_mouse_clk;
    assign mcu_mouse_data            = state_q.mcu_mouse_data;
    assign kbd_wake_data             = state_q.kbd_wake_data;
    assign mouse_wake_data           = state_q.mouse_wake_data;
    assign keyboard_interrupt        = state_q.kbd_irq_out;
    assign mouse_interrupt           = state_q.mouse_irq_out;
    assign microcontroller_port_line = state_q.port_line_out;
    assign address_line_twenty_gate  = state_q.a20_gate;
    assign keyboard_reset_out        = state_q.keyboard_reset_out_out;
    assign wake_slow_clock           = state_q.wake_clk;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence rsvd_read_taken;
        clken && s_axi_arvalid && s_axi_arready
        && ar_idx >= `KGC_RSVD_LO_IDX && ar_idx <= `KGC_RSVD_HI_IDX;
    endsequence

    sequence zero_answer;
        s_axi_rvalid && s_axi_rdata == 32'h0000_0000 && s_axi_rresp == `KGC_RESP_OKAY;
    endsequence

    a_port_polarity: assert property (@(posedge mclk) disable iff (!rstn)
        clken |=> microcontroller_port_line
                  == ($past(state_q.kbd_cfg[7]) ? $past(mcu_port_assert)
                      : !$past(mcu_port_assert)))
        else $error("port line polarity wrong");

    a_mouse_iso: assert property (@(posedge mclk) disable iff (!rstn)
        clken && state_q.kbd_cfg[`KGC_MOUSE_ISO_BIT]
        |=> mcu_mouse_clk && mcu_mouse_data)
        else $error("mouse lines not held idle while isolated");

    a_mouse_wake: assert property (@(posedge mclk) disable iff (!rstn)
        clken |=> mouse_wake_data == $past(mouse_data_line))
        else $error("mouse wake data not passed");

    a_kbd_iso: assert property (@(posedge mclk) disable iff (!rstn)
        clken |=> (mcu_kbd_data == ($past(state_q.kbd_cfg[5]) | $past(keyboard_data_line)))
                  && (mcu_kbd_clk == ($past(state_q.kbd_cfg[5]) | $past(kbd_clk_line))))
        else $error("keyboard isolation wrong");

    a_kbd_wake: assert property (@(posedge mclk) disable iff (!rstn)
        clken && state_q.kbd_cfg[`KGC_KBD_ISO_BIT]
        |=> kbd_wake_data == $past(keyboard_data_line))
        else $error("keyboard wake data blocked");

    a_mouse_irq: assert property (@(posedge mclk) disable iff (!rstn)
        clken |=> mouse_interrupt == ($past(state_q.kbd_cfg[4]) ? $past(state_q.mouse_latch)
                  : ($past(mcu_mouse_interrupt) & $past(state_q.mouse_latch))))
        else $error("mouse irq latch mode wrong");

    a_kbd_irq: assert property (@(posedge mclk) disable iff (!rstn)
        clken |=> keyboard_interrupt == ($past(state_q.kbd_cfg[3]) ? $past(state_q.kbd_latch)
                  : ($past(mcu_keyboard_interrupt) & $past(state_q.kbd_latch))))
        else $error("keyboard irq latch mode wrong");

    a_fast_port: assert property (@(posedge mclk) disable iff (!rstn)
        clken && !state_q.kbd_cfg[`KGC_FAST_EN_BIT]
        |=> !keyboard_reset_out && $stable(address_line_twenty_gate))
        else $error("fast port acted while disabled");

    a_rsvd_read: assert property (@(posedge mclk) disable iff (!rstn)
        rsvd_read_taken |=> zero_answer)
        else $error("reserved index did not read zero");

    a_wake_gate: assert property (@(posedge mclk) disable iff (!rstn)
        (wake_off || clk_absent) [*2] |-> !wake_slow_clock)
        else $error("slow clock reached disabled wake logic");

    a_wake_pass: assert property (@(posedge mclk) disable iff (!rstn)
        clken && !wake_off && !clk_absent |=> wake_slow_clock == $past(slow_clock_pin))
        else $error("slow clock not passed to enabled wake logic");

    a_read_answer: assert property (@(posedge mclk) disable iff (!rstn)
        clken && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read address taken without answer");

    a_write_done: assert property (@(posedge mclk) disable iff (!rstn)
        clken && s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");

endmodule

// ### rtl/keyboard_glue_config_params.svh
// offsets, field positions and reset values of the keyboard glue block
`ifndef KEYBOARD_GLUE_CONFIG_PARAMS_SVH
`define KEYBOARD_GLUE_CONFIG_PARAMS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define KGC_ADDR_W        14
`define KGC_KBD_CFG_IDX   12'h0f0
`define KGC_RSVD_LO_IDX   12'h0f1
`define KGC_RSVD_HI_IDX   12'h0ff
`define KGC_PME_CFG_IDX   12'h1f0
`define KGC_STATUS_IDX    12'h200

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define KGC_PORT_POL_BIT   7
`define KGC_MOUSE_ISO_BIT  6
`define KGC_KBD_ISO_BIT    5
`define KGC_MOUSE_IRQ_LATCH_MODE_BIT     4
`define KGC_KEY_IRQ_LATCH_MODE_BIT     3
`define KGC_FAST_EN_BIT    2
`define KGC_CLK_ABSENT_BIT 0
`define KGC_WAKE_OFF_BIT   1

// ----------------------------------------------------------------
// reset values, writable masks, bus answers
// ----------------------------------------------------------------
`define KGC_KBD_CFG_RST   8'h00
`define KGC_PME_CFG_RST   8'h00
`define KGC_KBD_CFG_MASK  8'hfc
`define KGC_PME_CFG_MASK  8'h03
`define KGC_RESP_OKAY     2'h0
`define KGC_RESP_DECERR   2'h3

`endif

// ### rtl/keyboard_glue_config_pkg.sv
// types of the keyboard glue block
package keyboard_glue_config_pkg;

    typedef logic [11:0] reg_idx_t;
    typedef logic [7:0]  reg_byte_t;

    typedef struct packed {
        reg_byte_t   kbd_cfg;
        reg_byte_t   pme_cfg;
        logic        aw_got;
        reg_idx_t    aw_idx;
        logic        w_got;
        reg_byte_t   w_data;
        logic        w_strb0;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        kbd_latch;
        logic        mouse_latch;
        logic        kbd_irq_prev;
        logic        mouse_irq_prev;
        logic        kbd_irq_out;
        logic        mouse_irq_out;
        logic        mcu_kbd_clk;
        logic        mcu_kbd_data;
        logic        mcu_mouse_clk;
        logic        mcu_mouse_data;
        logic        kbd_wake_data;
        logic        mouse_wake_data;
        logic        port_line_out;
        logic        a20_gate;
        logic        keyboard_reset_out_out;
        logic        wake_clk;
    } state_s;

endpackage

// ### tb/kbd_mouse_lines_model.sv
// model of the keyboard and mouse connector lines
`timescale 1ns/100ps

module kbd_mouse_lines_model
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rstn,
    // next levels asked for by the bench
    input  wire logic [3:0] pattern,
    // kbd clock, kbd data, mouse clock, mouse data
    output logic      [3:0] lines
);
    // lines carry pull-ups, so reset shows them high
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            lines <= 4'hf;
        else
            lines <= pattern;
    end
endmodule

// ### tb/test_keyboard_glue_config.sv
// self-checking bench of the keyboard glue configuration block
`timescale 1ns/100ps

module test_keyboard_glue_config;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        mclk = 1'b0, rstn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        irq_ack = 1'b0, fast_port_wr = 1'b0, mon_on = 1'b0, mcu_port_assert = 1'b0;
    logic        mcu_keyboard_interrupt = 1'b0, mcu_mouse_interrupt = 1'b0, slow_clock_pin = 1'b0;
    logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rnd;
    logic [3:0]  s_axi_wstrb = 4'h0, pattern = 4'hf, lines;
    logic [1:0]  s_axi_bresp, s_axi_rresp, fast_port_data = 2'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        keyboard_interrupt, mouse_interrupt, microcontroller_port_line;
    logic        address_line_twenty_gate, keyboard_reset_out, wake_slow_clock;
    logic        mcu_kbd_clk, mcu_kbd_data, mcu_mouse_clk, mcu_mouse_data;
    logic        kbd_wake_data, mouse_wake_data;
    logic [7:0]  kcfg = 8'h00, pcfg = 8'h00, exp_mon = 8'hff;
    logic [9:0]  corner [4] = '{10'h000, 10'h3ff, 10'h140, 10'h220};
    logic [3:0]  irq_tab [7] = '{4'b0100, 4'b1011, 4'b1100, 4'b0000, 4'b1111, 4'b1011, 4'b0001};
    int          err_count = 0, num_checks = 0;

    always #2 mclk = ~mclk;

    keyboard_glue_config i_dut
    (
        .mclk, .rstn, .clken(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .kbd_clk_line(lines[0]), .keyboard_data_line(lines[1]),
        .mouse_clk_line(lines[2]), .mouse_data_line(lines[3]),
        .mcu_kbd_clk, .mcu_kbd_data, .mcu_mouse_clk, .mcu_mouse_data,
        .kbd_wake_data, .mouse_wake_data, .mcu_keyboard_interrupt, .mcu_mouse_interrupt,
        .irq_ack, .mcu_port_assert, .keyboard_interrupt, .mouse_interrupt,
        .microcontroller_port_line, .fast_port_wr, .fast_port_data,
        .address_line_twenty_gate, .keyboard_reset_out, .slow_clock_pin, .wake_slow_clock
    );

    kbd_mouse_lines_model i_lines
    (
        .mclk, .rstn, .pattern, .lines
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one transfer; every channel held until its own ready edge
    task automatic axi(input logic wr, input logic [13:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic [1:0] r);
        int   n;
        logic dn;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_bready <= wr;
        s_axi_arvalid <= !wr;
        s_axi_rready <= !wr;
        n = 0;
        dn = 1'b0;
        r = 2'h2;
        q = '1;
        while (!dn && n < 50)
        begin
            @(posedge mclk);
            n++;
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
            if ((wr && s_axi_bvalid === 1'b1) || (!wr && s_axi_rvalid === 1'b1))
            begin
                dn = 1'b1;
                r = wr ? s_axi_bresp : s_axi_rresp;
                q = s_axi_rdata;
                s_axi_bready <= 1'b0;
                s_axi_rready <= 1'b0;
            end
        end
    endtask

    task automatic wrc(input logic [13:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [31:0] q;
        logic [1:0]  r;
        axi(1'b1, a, d, q, r);
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rdc(input logic [13:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] q;
        logic [1:0]  r;
        axi(1'b0, a, 32'h0, q, r);
        chk("rresp", {30'h0, er}, {30'h0, r});
        chk("rdata", e, q);
    endtask

    task automatic irq(input logic [3:0] t, input logic km, input logic mm);
        @(posedge mclk);
        mcu_keyboard_interrupt <= t[3];
        mcu_mouse_interrupt <= t[3];
        irq_ack <= t[2];
        @(posedge mclk);
        irq_ack <= 1'b0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk("keyboard_interrupt", {31'h0, km ? t[0] : t[1]}, {31'h0, keyboard_interrupt});
        chk("mouse_interrupt", {31'h0, mm ? t[0] : t[1]}, {31'h0, mouse_interrupt});
    endtask

    task automatic fport(input logic [1:0] d, input logic eg, input logic ek);
        int c;
        @(posedge mclk);
        fast_port_wr <= 1'b1;
        fast_port_data <= d;
        @(posedge mclk);
        fast_port_wr <= 1'b0;
        c = 0;
        repeat (4)
        begin
            @(negedge mclk);
            if (keyboard_reset_out === 1'b1)
                c++;
        end
        chk("address_line_twenty_gate", {31'h0, eg}, {31'h0, address_line_twenty_gate});
        chk("keyboard_reset_pulses", {31'h0, ek}, c);
    endtask

    // ----------------------------------------------------------------
    // line monitor: outputs are registered copies one edge late
    // ----------------------------------------------------------------
    always @(posedge mclk)
        exp_mon <= {kcfg[5] | lines[0], kcfg[5] | lines[1], kcfg[6] | lines[2],
                    kcfg[6] | lines[3], lines[1], lines[3], kcfg[7] ~^ mcu_port_assert,
                    slow_clock_pin & ~pcfg[1] & ~pcfg[0]};

    always @(negedge mclk)
    begin
        if (mon_on)
        begin
            chk("mcu_kbd_clk", {31'h0, exp_mon[7]}, {31'h0, mcu_kbd_clk});
            chk("mcu_kbd_data", {31'h0, exp_mon[6]}, {31'h0, mcu_kbd_data});
            chk("mcu_mouse_clk", {31'h0, exp_mon[5]}, {31'h0, mcu_mouse_clk});
            chk("mcu_mouse_data", {31'h0, exp_mon[4]}, {31'h0, mcu_mouse_data});
            chk("kbd_wake_data", {31'h0, exp_mon[3]}, {31'h0, kbd_wake_data});
            chk("mouse_wake_data", {31'h0, exp_mon[2]}, {31'h0, mouse_wake_data});
            chk("port_line", {31'h0, exp_mon[1]}, {31'h0, microcontroller_port_line});
            chk("wake_slow_clock", {31'h0, exp_mon[0]}, {31'h0, wake_slow_clock});
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rnd = 32'd65065;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        rdc(14'h3c0, 32'h0, 2'h0);
        rdc(14'h7c0, 32'h0, 2'h0);
        for (int i = 0; i < 16; i++)
        begin
            rnd = xs(rnd);
            {pcfg[1:0], kcfg} = (i < 4) ? corner[i] : rnd[9:0];
            wrc(14'h3c0, {rnd[31:8], kcfg}, 2'h0);
            wrc(14'h7c0, {rnd[29:0], pcfg[1:0]}, 2'h0);
            rdc(14'h3c0, {24'h0, kcfg & 8'hfc}, 2'h0);
            rdc(14'h7c0, {24'h0, pcfg & 8'h03}, 2'h0);
            repeat (2) @(posedge mclk);
            mon_on <= 1'b1;
            repeat (12)
            begin
                @(posedge mclk);
                rnd = xs(rnd);
                pattern <= rnd[3:0];
                mcu_port_assert <= rnd[4];
                slow_clock_pin <= rnd[5];
            end
            mon_on <= 1'b0;
        end
        // reserved places take writes silently and read zero
        for (int i = 8'hf1; i <= 8'hff; i++)
        begin
            wrc(14'(i * 4), xs(32'(i)), 2'h0);
            rdc(14'(i * 4), 32'h0, 2'h0);
        end
        rdc(14'h3c0, {24'h0, kcfg & 8'hfc}, 2'h0);
        wrc(14'h1000, 32'hff, 2'h3);
        rdc(14'h1000, 32'h0, 2'h3);
        // every pairing of the two latch modes
        for (int m = 0; m < 4; m++)
        begin
            kcfg = {3'h0, m[1], m[0], 3'h0};
            wrc(14'h3c0, {24'h0, kcfg}, 2'h0);
            for (int p = 0; p < 7; p++)
                irq(irq_tab[p], m[0], m[1]);
        end
        wrc(14'h3c0, 32'h0, 2'h0);
        fport(2'h3, 1'b0, 1'b0);
        wrc(14'h3c0, 32'h4, 2'h0);
        fport(2'h3, 1'b1, 1'b1);
        fport(2'h2, 1'b1, 1'b0);
        fport(2'h1, 1'b0, 1'b1);
        wrc(14'h3c0, 32'h0, 2'h0);
        fport(2'h2, 1'b0, 1'b0);
        rdc(14'h800, {28'h0, slow_clock_pin & ~|pcfg[1:0], 3'h3}, 2'h0);
        wrap_up();
    end

    // hang guard, well beyond the fewer than a thousand cycles the run needs
    initial
    begin
        #200000;
        err_count++;
        $display("ERROR watchdog expected finish seen timeout");
        wrap_up();
    end
endmodule
